// ===== blrt_pkg.sv
package blrt_pkg;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int LOG_DEPTH = 16;
  localparam int NUM_DIR = 2;
  localparam int DIR_AB = 0;
  localparam int DIR_BA = 1;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_AB_DATA = 8'h08;
  localparam logic [7:0] OFF_BA_DATA = 8'h0c;
  localparam logic [7:0] OFF_LOG = 8'h10;

  // ctrl fields
  localparam int CTRL_LOG_EN = 0;
  localparam int CTRL_LOG_DIR = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // status fields
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_OVF = 2;
  localparam int ST_FAST = 3;
  localparam int ST_AB_MODE = 4;
  localparam int ST_BA_MODE = 8;

  // log word fields
  localparam int LOG_DIR_BIT = 30;
  localparam int LOG_VALID_BIT = 31;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latchEnable;
    logic clockEnableN;
    logic clock;
    logic outputEnableN;
  } blrt_dir_ctrl_s;

  typedef enum logic [2:0] {
    MODE_ISOLATION,
    MODE_TRANSPARENT,
    MODE_CLOCKED,
    MODE_LATCHED,
    MODE_INHIBIT
  } blrt_mode_e;

  typedef struct packed {
    logic dir;
    logic [DATA_W-1:0] data;
  } blrt_log_s;

endpackage

// ===== blrt_transceiver.sv

// ------------------------------------------------------------------
// capture log fifo
// ------------------------------------------------------------------
module blrt_fifo
  import blrt_pkg::*;
#(
  parameter int WIDTH = DATA_W + 1,
  parameter int DEPTH = LOG_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic inValid, // push request
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word to push
  output logic outValid, // word available
  input wire logic outReady, // pop request
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, wrPtr_d;
  logic [AW:0] rdPtr_q, rdPtr_d;
  logic push, pop;

  assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData = mem[rdPtr_q[AW-1:0]];

  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule

// ------------------------------------------------------------------
// transceiver top
// ------------------------------------------------------------------
module blrt_transceiver
  import blrt_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = LOG_DEPTH
) (
  input wire logic clk, // system clock, 50 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [ADDR_W-1:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire blrt_dir_ctrl_s aToBCtrl, // a-to-b controls
  input wire blrt_dir_ctrl_s bToACtrl, // b-to-a controls
  input wire logic edgeRateSelect, // b edge speed select
  input wire logic [WIDTH-1:0] aIn, // a port level
  output logic [WIDTH-1:0] aOut, // a port drive value
  output logic [WIDTH-1:0] aOeN, // a port drive enable, low drives
  input wire logic [WIDTH-1:0] bIn, // b port level
  output logic [WIDTH-1:0] bOut, // b port drive value
  output logic [WIDTH-1:0] bOeN, // b port drive enable, low drives
  output logic bFastEdge, // b port fast edges
  output logic logReady // capture log can accept
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic blrt_mode_e modeOf(input blrt_dir_ctrl_s c);
    if (c.outputEnableN) begin
      return MODE_ISOLATION;
    end else if (c.latchEnable) begin
      return MODE_TRANSPARENT;
    end else if (c.clockEnableN) begin
      return MODE_INHIBIT;
    end
    return c.clock ? MODE_LATCHED : MODE_CLOCKED;
  endfunction

  // ----------------------------------------------------------------
  // per-direction storage
  // ----------------------------------------------------------------
  blrt_dir_ctrl_s ctrl [NUM_DIR];
  logic [WIDTH-1:0] src [NUM_DIR];
  logic [WIDTH-1:0] store_q [NUM_DIR];
  logic [WIDTH-1:0] storeNext [NUM_DIR];
  logic oeN_q [NUM_DIR];
  logic capture [NUM_DIR];

  assign ctrl[DIR_AB] = aToBCtrl;
  assign ctrl[DIR_BA] = bToACtrl;
  assign src[DIR_AB] = aIn;
  assign src[DIR_BA] = bIn;

  for (genvar d = 0; d < NUM_DIR; d++) begin : g_dir
    logic [WIDTH-1:0] store_d;
    logic clkPrev_q, clkPrev_d;
    logic lePrev_q, lePrev_d;
    logic oeN_d;
    logic clkRise, leFall;

    // next stored word, also seen by the capture log
    assign storeNext[d] = store_d;

    always_comb begin
      clkRise = ctrl[d].clock && !clkPrev_q;
      leFall = lePrev_q && !ctrl[d].latchEnable;
      clkPrev_d = ctrl[d].clock;
      lePrev_d = ctrl[d].latchEnable;
      oeN_d = ctrl[d].outputEnableN;
      if (ctrl[d].latchEnable) begin
        store_d = src[d];
      end else if (!ctrl[d].clockEnableN && clkRise) begin
        store_d = src[d];
      end else begin
        store_d = store_q[d];
      end
      capture[d] = leFall || (!ctrl[d].latchEnable && !ctrl[d].clockEnableN && clkRise);
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        store_q[d] <= '0;
        clkPrev_q <= 1'b0;
        lePrev_q <= 1'b0;
        oeN_q[d] <= 1'b1;
      end else begin
        store_q[d] <= store_d;
        clkPrev_q <= clkPrev_d;
        lePrev_q <= lePrev_d;
        oeN_q[d] <= oeN_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------
  logic fast_q;

  assign bOut = store_q[DIR_AB];
  assign bOeN = {WIDTH{oeN_q[DIR_AB]}};
  assign aOut = store_q[DIR_BA];
  assign aOeN = {WIDTH{oeN_q[DIR_BA]}};
  assign bFastEdge = fast_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_q <= 1'b0;
    end else begin
      fast_q <= edgeRateSelect;
    end
  end

  // ----------------------------------------------------------------
  // capture log
  // ----------------------------------------------------------------
  logic [1:0] ctrlReg_q, ctrlReg_d;
  logic ovf_q, ovf_d;
  logic pushValid, popReady, headValid;
  blrt_log_s pushWord, headWord;
  logic logDir;

  always_comb begin
    logDir = ctrlReg_q[CTRL_LOG_DIR];
    pushValid = ctrlReg_q[CTRL_LOG_EN] && capture[logDir];
    pushWord.dir = logDir;
    pushWord.data = logDir ? storeNext[DIR_BA] : storeNext[DIR_AB];
  end

  blrt_fifo #(
    .WIDTH($bits(blrt_log_s)),
    .DEPTH(DEPTH)
  ) u_log (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(pushValid),
    .inReady(logReady),
    .inData(pushWord),
    .outValid(headValid),
    .outReady(popReady),
    .outData(headWord)
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic access, wrAccess, rdAccess, mapped;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CTRL, OFF_STATUS, OFF_AB_DATA, OFF_BA_DATA, OFF_LOG: begin
        return 1'b1;
      end
      default: return 1'b0;
    endcase
  endfunction

  // zero wait states
  assign pready = 1'b1;

  always_comb begin
    access = psel && penable;
    wrAccess = access && pwrite;
    rdAccess = access && !pwrite;
    mapped = addrMapped(paddr);
    popReady = rdAccess && (paddr == OFF_LOG);
    ctrlReg_d = ctrlReg_q;
    if (wrAccess && paddr == OFF_CTRL) begin
      ctrlReg_d = pwdata[1:0];
    end
    ovf_d = ovf_q;
    if (wrAccess && paddr == OFF_STATUS && pwdata[ST_OVF]) begin
      ovf_d = 1'b0;
    end
    // new overflow wins over a clear
    if (pushValid && !logReady) begin
      ovf_d = 1'b1;
    end
    // read mux
    rdMux = 32'h0;
    case (paddr)
      OFF_CTRL: rdMux[1:0] = ctrlReg_q;
      OFF_STATUS: begin
        rdMux[ST_EMPTY] = !headValid;
        rdMux[ST_FULL] = !logReady;
        rdMux[ST_OVF] = ovf_q;
        rdMux[ST_FAST] = fast_q;
        rdMux[ST_AB_MODE +: 3] = modeOf(aToBCtrl);
        rdMux[ST_BA_MODE +: 3] = modeOf(bToACtrl);
      end
      OFF_AB_DATA: rdMux[WIDTH-1:0] = store_q[DIR_AB];
      OFF_BA_DATA: rdMux[WIDTH-1:0] = store_q[DIR_BA];
      OFF_LOG: begin
        if (headValid) begin
          rdMux[WIDTH-1:0] = headWord.data;
          rdMux[LOG_DIR_BIT] = headWord.dir;
          rdMux[LOG_VALID_BIT] = 1'b1;
        end
      end
      default: rdMux = 32'h0;
    endcase
    prdata = rdAccess ? rdMux : 32'h0;
    pslverr = access && !mapped;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlReg_q <= CTRL_RST;
      ovf_q <= 1'b0;
    end else begin
      ctrlReg_q <= ctrlReg_d;
      ovf_q <= ovf_d;
    end
  end

endmodule

// ===== blrt_backplane.sv
// ----
// backplane with other cards, terminated high
// ----
module blrt_backplane
  import blrt_pkg::*;
(
  input wire logic clk, // clock
  input wire logic slow, // answer a cycle late
  input wire logic drvOn, // other card drives
  input wire logic [DATA_W-1:0] drv, // its value
  input wire logic [DATA_W-1:0] bOut, // our value
  input wire logic [DATA_W-1:0] bOeN, // our enable
  output logic [DATA_W-1:0] bIn // bus level
);
  logic [DATA_W-1:0] late_q;
  always_ff @(posedge clk) late_q <= drv;
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      bIn[i] = !bOeN[i] ? bOut[i] : !drvOn ? 1'b1 : slow ? late_q[i] : drv[i];
    end
  end
endmodule

// ===== blrt_transceiver_props.sv
module blrt_props
  import blrt_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire blrt_dir_ctrl_s aToBCtrl, // a-to-b
  input wire blrt_dir_ctrl_s bToACtrl, // b-to-a
  input wire logic edgeRateSelect, // edge select
  input wire logic [WIDTH-1:0] aIn, // a level
  input wire logic [WIDTH-1:0] bIn, // b level
  input wire logic [WIDTH-1:0] aOut, // a value
  input wire logic [WIDTH-1:0] aOeN, // a enable
  input wire logic [WIDTH-1:0] bOut, // b value
  input wire logic [WIDTH-1:0] bOeN, // b enable
  input wire logic bFastEdge // fast edges
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_b_isolate: assert property (aToBCtrl.outputEnableN |=> &bOeN)
    else $error("b port not isolated");
  a_b_drive: assert property (!aToBCtrl.outputEnableN |=> bOeN == '0)
    else $error("b port not driven");
  a_ab_pass: assert property (aToBCtrl.latchEnable |=> bOut == $past(aIn))
    else $error("b port not transparent");
  a_ab_clocked: assert property ($past(arst_n) && !aToBCtrl.latchEnable
    && !aToBCtrl.clockEnableN && $rose(aToBCtrl.clock) |=> bOut == $past(aIn))
    else $error("clock edge not captured");
  a_ab_inhibit: assert property (!aToBCtrl.latchEnable && aToBCtrl.clockEnableN
    |=> $stable(bOut))
    else $error("inhibited store changed");
  a_ab_hold: assert property ($past(arst_n) && !aToBCtrl.latchEnable
    && !aToBCtrl.clockEnableN && !$rose(aToBCtrl.clock) |=> $stable(bOut))
    else $error("store changed without edge");
  a_ba_pass: assert property (bToACtrl.latchEnable |=> aOut == $past(bIn))
    else $error("a port not transparent");
  a_a_isolate: assert property (bToACtrl.outputEnableN |=> &aOeN)
    else $error("a port not isolated");
  a_edge_rate: assert property (1'b1 |=> bFastEdge == $past(edgeRateSelect))
    else $error("edge rate wrong");
endmodule

bind blrt_transceiver blrt_props #(.WIDTH(WIDTH)) i_blrt_props (.*);

// ===== testbench.sv
module testbench;
  import blrt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic edgeRateSelect = 1'b0, drvOn = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, bFastEdge, logReady;
  logic [DATA_W-1:0] aIn = '0, drv = '0, aOut, aOeN, bIn, bOut, bOeN, v;
  blrt_dir_ctrl_s aToBCtrl = 4'h1, bToACtrl = 4'h1;
  logic [DATA_W-1:0] q[$];
  int failures = 0, checks_done = 0, cycles = 0;
  blrt_transceiver i_blrt_transceiver (.*);
  blrt_backplane i_blrt_backplane (.*);
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] logw(input logic [DATA_W-1:0] d);
    return 32'h8000_0000 | 32'(d);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cap(input logic [DATA_W-1:0] x);
    aIn <= x; aToBCtrl.clock <= 1'b0;
    @(posedge clk) aToBCtrl.clock <= 1'b1;
    @(posedge clk);
    @(negedge clk) chk(bOut, x);
    @(posedge clk);
  endtask
  task automatic conclude;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(32'h232a));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk) chk(bOeN, {DATA_W{1'b1}});
    @(posedge clk) aToBCtrl <= 4'h8;
    for (int i = 0; i < 8; i++) begin
      v = i == 0 ? '1 : i == 1 ? '0 : DATA_W'($urandom);
      @(posedge clk) aIn <= v;
      @(posedge clk);
      @(negedge clk) chk(bOut, v);
    end
    chk(bOeN, 0);
    @(posedge clk) aToBCtrl <= 4'h0;
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (17) begin
      v = DATA_W'($urandom);
      q.push_back(v);
      cap(v);
    end
    aIn <= ~v;
    repeat (3) @(posedge clk);
    @(negedge clk) chk(bOut, v);
    @(posedge clk) aToBCtrl.clockEnableN <= 1'b1;
    repeat (4) @(posedge clk) aToBCtrl.clock <= ~aToBCtrl.clock;
    @(negedge clk) chk(bOut, v);
    @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'b110);
    chk(rd[10:3], {3'(MODE_ISOLATION), 1'b0, 3'(MODE_INHIBIT), 1'b0});
    chk(logReady, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, OFF_LOG, 32'h0);
      chk(rd, logw(q[i]));
    end
    apb(1'b0, OFF_LOG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h4);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    apb(1'b0, OFF_AB_DATA, 32'h0);
    chk(rd, 32'(v));
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    aToBCtrl <= 4'h1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk(bOeN, {DATA_W{1'b1}});
    @(posedge clk) bToACtrl <= 4'h8;
    drvOn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = DATA_W'($urandom);
      slow <= i[0];
      drv <= v;
      repeat (3) @(posedge clk);
      @(negedge clk) chk(aOut, v);
      @(posedge clk);
    end
    chk(aOeN, 0);
    for (int i = 0; i < 2; i++) begin
      edgeRateSelect <= i[0];
      repeat (2) @(posedge clk);
      @(negedge clk) chk(bFastEdge, i[0]);
      @(posedge clk);
    end
    conclude();
  end
endmodule
